// ===== include/fwp_map.vh
// Register map, command codes and timing constants of the flash write protection block
// Function
// R1 - OTP reprogrammable, never erasable
// R2 - Second program in 16 bytes disables ECC
// R3 - OTP program out of range ignored
// R4 - OTP program under freeze sets error
// R5 - Freeze and lock bits guard the OTP area, mode bits do not
// R6 - Lock byte bits guard 32-byte regions
// R7 - Write enable sets the latch
// R8 - Latch cleared at reset and completion
// R9 - Block protect bits pick fraction
// R10 - Top-bottom bit places protected range
// R11 - Each half has own protection
// R12 - Block and sector protection ORed
// R13 - Freeze locks block bits and OTP
// R14 - Pin low plus disable bit locks registers
// R15 - Persistent or dynamic bit zero protects
// R16 - Lock zero blocks persistent bit changes
// R17 - Persistent mode: lock set, clear-only
// R18 - Password mode: lock cleared, password sets
// R19 - Mode bits select mode, 00 fails
// R20 - Mode selected blocks config changes, error
// R21 - Host programs password before mode
// R22 - Mode program holds write-in-progress busy
// R23 - Failed unlock: error, busy 100 us
// R24 - Address top bit selects half
`ifndef FWP_MAP_VH
`define FWP_MAP_VH
`define FWP_OFF_CMD        5'h00
`define FWP_OFF_ADDR       5'h04
`define FWP_OFF_WDATA      5'h08
`define FWP_OFF_STATUS     5'h0C
`define FWP_OFF_CONFIG     5'h10
`define FWP_OFF_QUERY      5'h14
`define FWP_OFF_PASS_LO    5'h18
`define FWP_OFF_PASS_HI    5'h1C
`define FWP_CMD_RESET      4'h0
`define FWP_CMD_WRITE_ENABLE_CMD       4'h1
`define FWP_CMD_WRITE_DISABLE_CMD       4'h2
`define FWP_CMD_PROGRAM    4'h3
`define FWP_CMD_ERASE      4'h4
`define FWP_CMD_BULK       4'h5
`define FWP_CMD_WRITE_ANY_REGISTER_CMD       4'h6
`define FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD       4'h7
`define FWP_CMD_MODEP      4'h8
`define FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD       4'h9
`define FWP_CMD_PERSISTENT_BIT_ERASE_CMD       4'hA
`define FWP_CMD_PASSWORD_PROGRAM_CMD      4'hB
`define FWP_CMD_LOCKCLR    4'hC
`define FWP_CMD_UNLOCK     4'hD
`define FWP_CMD_DYBWR      4'hE
`define FWP_WRITE_ANY_REGISTER_CMD_SR1       2'h0
`define FWP_WRITE_ANY_REGISTER_CMD_CR1       2'h1
`define FWP_WRITE_ANY_REGISTER_CMD_TRAIN     2'h2
`define FWP_ST_WIP         0
`define FWP_ST_WEL         1
`define FWP_ST_PERR        6
`define FWP_ST_STATUS_WRITE_DISABLE        7
`define FWP_MODE_NONE      2'h3
`define FWP_MODE_PASSWD    2'h1
`define FWP_OTP_LOCK_BASE  10'h010
`define FWP_CLK_MHZ        40
`define FWP_PGM_TIME_US    250
`define FWP_UNLOCK_TIME_US 100
`endif

// ===== logic/fwp_protect.v
// Flash write protection logic: latch, block, sector and one-time area guards
`timescale 1ns/1ps
`default_nettype none
`include "fwp_map.vh"

module fwp_protect #(
  parameter integer PGM_CYCLES = `FWP_PGM_TIME_US * `FWP_CLK_MHZ,
  parameter integer SECT_BITS  = 8
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        srst_i,
  // Pins
  input  wire        wp_n_i,
  input  wire        hw_reset_n_i,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Main array launch
  output wire        array_go_o,
  output wire [3:0]  array_cmd_o,
  output wire [31:0] array_addr_o,
  output wire [7:0]  array_data_o
);

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam integer HALF_BIT = SECT_BITS + 18;
  localparam integer NSECT    = 2 << SECT_BITS;
  localparam integer UNL_CYC  = `FWP_UNLOCK_TIME_US * `FWP_CLK_MHZ;
  localparam integer PGM_M1   = PGM_CYCLES - 1;
  localparam integer UNL_M1   = UNL_CYC - 1;
  localparam [23:0]  PGM_LOAD = PGM_M1[23:0];
  localparam [23:0]  UNL_LOAD = UNL_M1[23:0];

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Block protect decode for one half
  function bp_hit;
    input [2:0]           bp;
    input                 tb;
    input [SECT_BITS-1:0] s;
    reg   [SECT_BITS:0]   full;
    reg   [SECT_BITS:0]   n;
    begin
      full = {1'b1, {SECT_BITS{1'b0}}};
      n    = (bp == 3'h0) ? {(SECT_BITS+1){1'b0}} : (full >> (3'h7 - bp)); // R9
      if (tb) begin
        bp_hit = ({1'b0, s} < n); // R10
      end else begin
        bp_hit = ({1'b0, s} >= (full - n));
      end
    end
  endfunction

  // Byte-lane merge for writable words
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        be_merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [2:0]       wp_s_reg;
  reg [2:0]       hr_s_reg;
  reg             wp_lvl_reg;
  reg             hr_lvl_reg;
  reg             ack_reg;
  reg [31:0]      rdata_reg;
  reg [3:0]       last_cmd_reg;
  reg [31:0]      addr_reg;
  reg [31:0]      wdata_reg;
  reg [31:0]      pw_lo_reg;
  reg [31:0]      pw_hi_reg;
  reg [2:0]       bp_reg [0:1];
  reg [1:0]       tb_reg;
  reg [1:0]       lock_reg;
  reg             status_write_disable_reg;
  reg             freeze_reg;
  reg [1:0]       mode_reg;
  reg [63:0]      pass_reg;
  reg [7:0]       train_reg;
  reg             wel_reg;
  reg             perr_reg;
  reg             busy_reg;
  reg             clr_pend_reg;
  reg [23:0]      cnt_reg;
  reg [NSECT-1:0] ppb_reg;
  reg [NSECT-1:0] dyb_reg;
  reg [7:0]       otp_mem [0:1023];
  reg [63:0]      ecc_seen_reg;
  reg [63:0]      ecc_off_reg;
  reg             go_reg;
  reg [3:0]       acmd_reg;
  reg [31:0]      aaddr_reg;
  reg [7:0]       adata_reg;
  integer         i;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Bus handshake: one wait state per access
  wire acc    = (avs_read | avs_write) & ~ack_reg;
  wire wr_ok  = avs_write & ack_reg;
  wire cmd_go = wr_ok & (avs_address == `FWP_OFF_CMD) & avs_byteenable[0];
  wire [3:0] cmd = avs_writedata[3:0];

  // Half and sector selection from the command address
  wire                 half  = addr_reg[HALF_BIT]; // R24
  wire [SECT_BITS-1:0] sect  = addr_reg[HALF_BIT-1:18];
  wire [SECT_BITS:0]   sidx  = {half, sect};
  wire                 bprot = bp_hit(bp_reg[half], tb_reg[half], sect); // R11
  wire                 aprot = ~ppb_reg[sidx] | ~dyb_reg[sidx]; // R15
  wire                 sprot = bprot | aprot; // R12
  wire                 bulk_prot = (bp_reg[0] != 3'h0) | (bp_reg[1] != 3'h0) |
                                   ~(&ppb_reg) | ~(&dyb_reg);

  // One-time area decode
  wire       in_otp  = (addr_reg[31:10] == 22'h000000); // R3
  wire [9:0] oa      = addr_reg[9:0];
  wire [7:0] lk_byte = otp_mem[`FWP_OTP_LOCK_BASE + {8'h00, oa[9:8]}];
  wire       otp_lk  = ~lk_byte[oa[7:5]]; // R6

  // Guards
  wire mode_set = (mode_reg != `FWP_MODE_NONE);
  wire pwd_mode = (mode_reg == `FWP_MODE_PASSWD);
  wire sr_guard = ~wp_lvl_reg & status_write_disable_reg; // R14
  wire [63:0] pw_in = {pw_hi_reg, pw_lo_reg};
  wire free_cmd = (cmd == `FWP_CMD_RESET) | (cmd == `FWP_CMD_WRITE_ENABLE_CMD) |
                  (cmd == `FWP_CMD_WRITE_DISABLE_CMD) | (cmd == `FWP_CMD_UNLOCK);
  wire exec = cmd_go & ~busy_reg & (wel_reg | free_cmd); // R7

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Level changes once second and third stage agree
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      wp_s_reg   <= 3'h7;
      hr_s_reg   <= 3'h7;
      wp_lvl_reg <= 1'b1;
      hr_lvl_reg <= 1'b1;
    end else begin
      wp_s_reg <= {wp_s_reg[1:0], wp_n_i};
      hr_s_reg <= {hr_s_reg[1:0], hw_reset_n_i};
      if (wp_s_reg[1] == wp_s_reg[2]) begin
        wp_lvl_reg <= wp_s_reg[2];
      end
      if (hr_s_reg[1] == hr_s_reg[2]) begin
        hr_lvl_reg <= hr_s_reg[2];
      end
    end
  end

  // ------------------------------------------------------------
  // Avalon slave
  // ------------------------------------------------------------
  // Read data captured in the wait cycle, stands in the answer cycle
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
      addr_reg  <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      pw_lo_reg <= 32'hFFFFFFFF;
      pw_hi_reg <= 32'hFFFFFFFF;
    end else begin
      ack_reg <= acc;
      if (acc & avs_read) begin
        case (avs_address)
          `FWP_OFF_CMD:    rdata_reg <= {28'h0000000, last_cmd_reg};
          `FWP_OFF_ADDR:   rdata_reg <= addr_reg;
          `FWP_OFF_WDATA:  rdata_reg <= wdata_reg;
          `FWP_OFF_STATUS: rdata_reg <= {24'h000000, status_write_disable_reg, perr_reg, 4'h0,
                                         wel_reg, busy_reg};
          `FWP_OFF_CONFIG: rdata_reg <= {18'h00000, wp_lvl_reg, lock_reg, mode_reg,
                                         freeze_reg, tb_reg[1], bp_reg[1],
                                         tb_reg[0], bp_reg[0]};
          `FWP_OFF_QUERY:  rdata_reg <= {16'h0000, train_reg, 3'h0, dyb_reg[sidx],
                                         ppb_reg[sidx], ecc_off_reg[oa[9:4]],
                                         otp_lk, sprot};
          default:         rdata_reg <= 32'h00000000;
        endcase
      end
      if (wr_ok) begin
        case (avs_address)
          `FWP_OFF_ADDR:    addr_reg  <= be_merge(addr_reg, avs_writedata, avs_byteenable);
          `FWP_OFF_WDATA:   wdata_reg <= be_merge(wdata_reg, avs_writedata, avs_byteenable);
          `FWP_OFF_PASS_LO: pw_lo_reg <= be_merge(pw_lo_reg, avs_writedata, avs_byteenable);
          `FWP_OFF_PASS_HI: pw_hi_reg <= be_merge(pw_hi_reg, avs_writedata, avs_byteenable);
          default:          ;
        endcase
      end
    end
  end

  assign avs_waitrequest = acc;
  assign avs_readdata    = rdata_reg;

  // ------------------------------------------------------------
  // Command engine
  // ------------------------------------------------------------
  // Power-on defaults, hardware reset of volatile state, command execution
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      bp_reg[0]    <= 3'h0;
      bp_reg[1]    <= 3'h0;
      tb_reg       <= 2'h0;
      lock_reg     <= 2'h3; // R17
      status_write_disable_reg     <= 1'b0;
      freeze_reg   <= 1'b0;
      mode_reg     <= `FWP_MODE_NONE;
      pass_reg     <= 64'hFFFFFFFFFFFFFFFF;
      train_reg    <= 8'h00;
      wel_reg      <= 1'b0; // R8
      perr_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      clr_pend_reg <= 1'b0;
      cnt_reg      <= 24'h000000;
      ppb_reg      <= {NSECT{1'b1}};
      dyb_reg      <= {NSECT{1'b1}};
      ecc_seen_reg <= 64'h0000000000000000;
      ecc_off_reg  <= 64'h0000000000000000;
      go_reg       <= 1'b0;
      acmd_reg     <= 4'h0;
      aaddr_reg    <= 32'h00000000;
      adata_reg    <= 8'h00;
      last_cmd_reg <= 4'h0;
      for (i = 0; i < 1024; i = i + 1) begin
        otp_mem[i] <= 8'hFF;
      end
    end else if (~hr_lvl_reg) begin
      // Hardware reset held: volatile protection state to defaults
      wel_reg      <= 1'b0; // R8
      lock_reg     <= pwd_mode ? 2'h0 : 2'h3; // R17 R18
      dyb_reg      <= {NSECT{1'b1}};
      busy_reg     <= 1'b0;
      clr_pend_reg <= 1'b0;
      go_reg       <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      // Software clears the error flag; a new error below wins
      if (wr_ok & (avs_address == `FWP_OFF_STATUS) & avs_writedata[`FWP_ST_PERR]) begin
        perr_reg <= 1'b0;
      end
      // Busy countdown, latch cleared on completion of a timed command
      if (busy_reg) begin
        if (cnt_reg == 24'h000000) begin
          busy_reg     <= 1'b0;
          clr_pend_reg <= 1'b0;
          if (clr_pend_reg) begin
            wel_reg <= 1'b0; // R8
          end
        end else begin
          cnt_reg <= cnt_reg - 24'h000001;
        end
      end
      if (exec) begin
        last_cmd_reg <= cmd;
        // Timed commands run for one program time, a failed unlock for the unlock time
        if ((cmd >= `FWP_CMD_PROGRAM) & (cmd <= `FWP_CMD_PASSWORD_PROGRAM_CMD) &
            ~((cmd == `FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD) & ~in_otp)) begin
          busy_reg     <= 1'b1; // R22
          cnt_reg      <= PGM_LOAD;
          clr_pend_reg <= 1'b1;
        end
        case (cmd)
          `FWP_CMD_RESET, `FWP_CMD_WRITE_DISABLE_CMD: begin
            wel_reg <= 1'b0; // R8
          end
          `FWP_CMD_WRITE_ENABLE_CMD: begin
            wel_reg <= 1'b1; // R7
          end
          `FWP_CMD_PROGRAM, `FWP_CMD_ERASE, `FWP_CMD_BULK: begin
            if ((cmd == `FWP_CMD_BULK) ? bulk_prot : sprot) begin
              perr_reg <= 1'b1; // R12
            end else begin
              go_reg    <= 1'b1;
              acmd_reg  <= cmd;
              aaddr_reg <= addr_reg;
              adata_reg <= wdata_reg[7:0];
            end
          end
          `FWP_CMD_WRITE_ANY_REGISTER_CMD: begin
            case (addr_reg[1:0])
              `FWP_WRITE_ANY_REGISTER_CMD_SR1: begin
                if (sr_guard) begin
                  perr_reg <= 1'b1; // R14
                end else begin
                  status_write_disable_reg <= wdata_reg[`FWP_ST_STATUS_WRITE_DISABLE];
                  if (~freeze_reg) begin
                    bp_reg[half] <= wdata_reg[4:2]; // R13
                  end
                end
              end
              `FWP_WRITE_ANY_REGISTER_CMD_CR1: begin
                if (sr_guard | (mode_set & (wdata_reg[5] != tb_reg[half]))) begin
                  perr_reg <= 1'b1; // R14 R20
                end else begin
                  freeze_reg <= freeze_reg | wdata_reg[0]; // R13
                  if (~freeze_reg) begin
                    tb_reg[half] <= wdata_reg[5]; // R10
                  end
                end
              end
              `FWP_WRITE_ANY_REGISTER_CMD_TRAIN: begin
                if (mode_set) begin
                  perr_reg <= 1'b1; // R20
                end else begin
                  train_reg <= wdata_reg[7:0];
                end
              end
              default: ;
            endcase
          end
          `FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD: begin
            // Mode bits play no part here
            if (in_otp) begin
              if (freeze_reg | otp_lk) begin
                perr_reg <= 1'b1; // R4 R5 R6
              end else begin
                otp_mem[oa] <= otp_mem[oa] & wdata_reg[7:0]; // R1
                if (ecc_seen_reg[oa[9:4]]) begin
                  ecc_off_reg[oa[9:4]] <= 1'b1; // R2
                end
                ecc_seen_reg[oa[9:4]] <= 1'b1;
              end
            end
          end
          `FWP_CMD_MODEP: begin
            if (mode_set | (wdata_reg[2:1] == 2'h0)) begin
              perr_reg <= 1'b1; // R19 R20
            end else begin
              mode_reg <= wdata_reg[2:1]; // R19
            end
          end
          `FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD: begin
            if (~lock_reg[half]) begin
              perr_reg <= 1'b1; // R16
            end else begin
              ppb_reg[sidx] <= 1'b0;
            end
          end
          `FWP_CMD_PERSISTENT_BIT_ERASE_CMD: begin
            if (~lock_reg[half]) begin
              perr_reg <= 1'b1; // R16
            end else begin
              for (i = 0; i < NSECT; i = i + 1) begin
                if ((i / (NSECT / 2)) == half) begin
                  ppb_reg[i] <= 1'b1;
                end
              end
            end
          end
          `FWP_CMD_PASSWORD_PROGRAM_CMD: begin
            if (mode_set) begin
              perr_reg <= 1'b1; // R20
            end else begin
              pass_reg <= pass_reg & pw_in;
            end
          end
          `FWP_CMD_LOCKCLR: begin
            lock_reg[half] <= 1'b0; // R17 R18
          end
          `FWP_CMD_UNLOCK: begin
            if (pwd_mode & (pw_in == pass_reg)) begin
              lock_reg[half] <= 1'b1; // R18
            end else begin
              perr_reg <= 1'b1; // R23
              busy_reg <= 1'b1;
              cnt_reg  <= UNL_LOAD;
            end
          end
          `FWP_CMD_DYBWR: begin
            dyb_reg[sidx] <= wdata_reg[0];
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign array_go_o   = go_reg;
  assign array_cmd_o  = acmd_reg;
  assign array_addr_o = aaddr_reg;
  assign array_data_o = adata_reg;

endmodule
`default_nettype wire

// ===== testbench/fwp_protect_properties.sv
// Port-level checks of the flash write protection block
`timescale 1ns/1ps
`default_nettype none
module fwp_protect_props #(
  parameter integer PGM_CYCLES = 20,
  parameter integer SECT_BITS  = 8
) (
  input wire        sys_clk_i,
  input wire        srst_i,
  input wire        wp_n_i,
  input wire        hw_reset_n_i,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        array_go_o,
  input wire [3:0]  array_cmd_o,
  input wire [31:0] array_addr_o,
  input wire [7:0]  array_data_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Bus answers after exactly one wait state
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state not one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait request without a request");
  a_rdata_hold: assert property (!$stable(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without a read");
  // Array launch is a single pulse caused by a taken command write
  a_go_single: assert property (array_go_o |=> !array_go_o)
    else $error("launch pulse longer than one cycle");
  a_go_cause: assert property (array_go_o |->
    $past(avs_write && !avs_waitrequest && avs_address == 5'h00)) else $error("launch without command");
  a_go_kind: assert property (array_go_o |-> array_cmd_o inside {4'h3, 4'h4, 4'h5})
    else $error("launch of a non array command");
  a_go_code: assert property (array_go_o |-> array_cmd_o == $past(avs_writedata[3:0]))
    else $error("launch code differs from command");
  a_launch_hold: assert property (!$stable(array_cmd_o) || !$stable(array_addr_o) |-> array_go_o)
    else $error("launch fields moved without a pulse");
  a_hwrst_quiet: assert property (!hw_reset_n_i [*5] |-> !array_go_o)
    else $error("launch during hardware reset");
endmodule
bind fwp_protect fwp_protect_props #(.PGM_CYCLES(PGM_CYCLES), .SECT_BITS(SECT_BITS)) i_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wp_n_i(wp_n_i), .hw_reset_n_i(hw_reset_n_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .array_go_o(array_go_o),
  .array_cmd_o(array_cmd_o), .array_addr_o(array_addr_o), .array_data_o(array_data_o));
`default_nettype wire

// ===== testbench/fwp_host.sv
// Avalon-MM master model of the host controller
`timescale 1ns/1ps
`default_nettype none
`include "fwp_map.vh"
module fwp_host (
  // Clock
  input  wire logic        clk_i,
  // Avalon-MM master
  output var  logic [4:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  logic polling = 1'b0;
  // Idle bus at time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
  end
  // One transfer held until wait request is seen low
  task automatic xfer(input bit rd, input [4:0] a, input [31:0] d, output [31:0] q);
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Poll write in progress until it falls
  task automatic poll();
    logic [31:0] s;
    polling <= 1'b1;
    for (int n = 0; n < 6000; n++) begin
      xfer(1, `FWP_OFF_STATUS, 32'h0, s);
      if (s[`FWP_ST_WIP] === 1'b0) break;
    end
    polling <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/fwp_protect_test.sv
// Self-checking bench of the flash write protection block
`timescale 1ns/1ps
`default_nettype none
`include "fwp_map.vh"
module fwp_protect_test;
  logic        sys_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  logic        hw_reset_n_i = 1'b1;
  wire  [4:0]  avs_address;
  wire         avs_read;
  wire         avs_write;
  wire         avs_waitrequest;
  wire         array_go_o;
  wire  [3:0]  avs_byteenable;
  wire  [3:0]  array_cmd_o;
  wire  [31:0] avs_writedata;
  wire  [31:0] avs_readdata;
  wire  [31:0] array_addr_o;
  wire  [7:0]  array_data_o;
  logic [31:0] expq[$];
  logic [31:0] goq[$];
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  fwp_protect #(.PGM_CYCLES(20), .SECT_BITS(8)) i_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wp_n_i(wp_n_i), .hw_reset_n_i(hw_reset_n_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .array_go_o(array_go_o),
    .array_cmd_o(array_cmd_o), .array_addr_o(array_addr_o), .array_data_o(array_data_o));
  fwp_host i_host (
    .clk_i(sys_clk_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // Clock at 40 MHz
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Expected block protection of one half-array address
  function automatic logic pr(int bp, bit tb, logic [31:0] a);
    logic [26:0] sz;
    sz = bp == 0 ? 27'h0 : bp == 7 ? 27'h4000000 : 27'h1 << (19 + bp);
    return tb ? ({1'b0, a[25:0]} < sz) : ({1'b0, a[25:0]} >= 27'h4000000 - sz);
  endfunction
  task automatic wr(input [4:0] a, input [31:0] d);
    logic [31:0] q;
    i_host.xfer(0, a, d, q);
  endtask
  task automatic rd(input [4:0] a, input [31:0] e);
    logic [31:0] q;
    expq.push_back(e);
    i_host.xfer(1, a, 32'h0, q);
  endtask
  task automatic op(input [3:0] c, input [31:0] a, input [31:0] d);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_ENABLE_CMD);
    wr(`FWP_OFF_ADDR, a);
    wr(`FWP_OFF_WDATA, d);
    wr(`FWP_OFF_CMD, c);
    i_host.poll();
  endtask
  task automatic qy(input [31:0] a, input [31:0] e);
    wr(`FWP_OFF_ADDR, a);
    rd(`FWP_OFF_QUERY, e);
  endtask
  // Compare read data and launches against the oldest note, and cut hangs
  always @(posedge sys_clk_i) begin
    if (avs_read && !avs_waitrequest && !i_host.polling)
      chk("readdata", expq.size() ? expq.pop_front() : 32'hX, avs_readdata);
    if (array_go_o === 1'b1)
      chk("array_addr", goq.size() ? goq.pop_front() : 32'hX, array_addr_o);
    cyc++;
    if (cyc > 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] a;
    logic [31:0] s;
    int t;
    int b;
    int k;
    void'($urandom(41));
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd(`FWP_OFF_STATUS, 32'h0);
    rd(`FWP_OFF_CONFIG, 32'h3E00);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_ENABLE_CMD);
    rd(`FWP_OFF_STATUS, 32'h2);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_DISABLE_CMD);
    rd(`FWP_OFF_STATUS, 32'h0);
    $display("test latch done");
    for (t = 0; t < 2; t++) begin
      op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_CR1, t << 5);
      for (b = 0; b < 8; b++) begin
        op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_SR1, b << 2);
        s = b == 0 ? 32'h0 : b == 7 ? 32'h4000000 : 32'h1 << (19 + b);
        for (k = 0; k < 5; k++) begin
          a = k == 0 ? s : k == 1 ? s - 1 : k == 2 ? 32'h4000000 - s : 32'h3FFFFFF - s;
          a = (k == 4 ? $urandom : a) & 32'h3FFFFFF;
          qy(a, 32'h18 | pr(b, t, a));
          qy(a | 32'h4000000, 32'h18);
        end
      end
    end
    $display("test block protect done");
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_CR1, 32'h0);
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_SR1, 32'h4);
    goq.push_back(32'h100);
    op(`FWP_CMD_PROGRAM, 32'h100, $urandom & 32'hFF);
    op(`FWP_CMD_PROGRAM, 32'h3FFFF00, 32'h5A);
    goq.push_back(32'h7FC0000);
    op(`FWP_CMD_ERASE, 32'h7FC0000, 32'h0);
    op(`FWP_CMD_DYBWR, 32'h40000, 32'h0);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_DISABLE_CMD);
    qy(32'h40000, 32'h09);
    op(`FWP_CMD_PROGRAM, 32'h40000, 32'hA5);
    $display("test launch done");
    op(`FWP_CMD_LOCKCLR, 32'h0, 32'h0);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_DISABLE_CMD);
    rd(`FWP_OFF_CONFIG, 32'h3601);
    op(`FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, 32'h0, 32'h0);
    qy(32'h0, 32'h18);
    wr(`FWP_OFF_STATUS, 32'h40);
    op(`FWP_CMD_PERSISTENT_BIT_PROGRAM_CMD, 32'h4000000, 32'h0);
    qy(32'h4000000, 32'h11);
    $display("test sector bits done");
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, 32'h400, 32'h0);
    rd(`FWP_OFF_STATUS, 32'h2);
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_DISABLE_CMD);
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, 32'h20, 32'hAA);
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, 32'h21, 32'h55);
    rd(`FWP_OFF_STATUS, 32'h0);
    qy(32'h20, 32'h1C);
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, `FWP_OTP_LOCK_BASE, 32'hFE);
    qy(32'h0, 32'h1A);
    $display("test one time area done");
    op(`FWP_CMD_PASSWORD_PROGRAM_CMD, 32'h0, 32'h0);
    op(`FWP_CMD_MODEP, 32'h0, 32'h0);
    rd(`FWP_OFF_STATUS, 32'h40);
    wr(`FWP_OFF_STATUS, 32'h40);
    op(`FWP_CMD_MODEP, 32'h0, 32'h4);
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, 32'h40, 32'h0);
    rd(`FWP_OFF_STATUS, 32'h0);
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_CR1, 32'h20);
    rd(`FWP_OFF_STATUS, 32'h40);
    rd(`FWP_OFF_CONFIG, 32'h3401);
    wr(`FWP_OFF_STATUS, 32'h40);
    wr(`FWP_OFF_CMD, `FWP_CMD_UNLOCK);
    rd(`FWP_OFF_STATUS, 32'h41);
    i_host.poll();
    wr(`FWP_OFF_STATUS, 32'h40);
    $display("test mode done");
    wr(`FWP_OFF_CMD, `FWP_CMD_WRITE_ENABLE_CMD);
    hw_reset_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    hw_reset_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rd(`FWP_OFF_STATUS, 32'h0);
    rd(`FWP_OFF_CONFIG, 32'h3C01);
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_SR1, 32'h84);
    rd(`FWP_OFF_STATUS, 32'h80);
    wp_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_SR1, 32'h8C);
    rd(`FWP_OFF_CONFIG, 32'h1C01);
    rd(`FWP_OFF_STATUS, 32'hC0);
    wr(`FWP_OFF_STATUS, 32'h40);
    wp_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    $display("test pins done");
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_CR1, 32'h1);
    op(`FWP_CMD_WRITE_ANY_REGISTER_CMD, `FWP_WRITE_ANY_REGISTER_CMD_SR1, 32'h9C);
    rd(`FWP_OFF_CONFIG, 32'h3D01);
    op(`FWP_CMD_ONE_TIME_AREA_PROGRAM_CMD, 32'h60, 32'h0);
    rd(`FWP_OFF_STATUS, 32'hC0);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd(`FWP_OFF_CONFIG, 32'h3E00);
    repeat (4) @(posedge sys_clk_i);
    chk("launches_left", 32'h0, 32'(goq.size()));
    $display("test freeze done");
    report_and_stop();
  end
endmodule
`default_nettype wire
